// *** src/ivfs_top.sv ***
// Input voltage fault supervisor: command registers, fault status, restart control.
module ivfs_top #(
    parameter int CYC_MS  = ivfs_pkg::CYC_PER_MS,
    parameter int MIN_TON = ivfs_pkg::MIN_TON_CYC
) (
    input  wire logic                mclk_in,
    input  wire logic                rst_n_in,
    input  wire ivfs_pkg::ivfs_cmd_t cmd_in,
    input  wire logic                clear_faults_in,
    input  wire logic                restore_in,
    input  wire logic                start_in,
    input  wire logic [15:0]         power_input_voltage_in,
    input  wire logic [15:0]         rise_cycles_in,
    input  wire logic                pwm_clk_in,
    output logic [15:0]              rd_data_out,
    output logic                     rd_valid_out,
    output logic [15:0]              status_word_out,
    output logic [7:0]               status_input_out,
    output logic                     alert_n_out,
    output logic                     sw_en_out
);
    import ivfs_pkg::*;

    // ==========================================================
    // Linear format helper
    // Converts a linear word to 1/64 units so limits and readings share a scale.
    function automatic logic signed [31:0] lin_q(input logic [15:0] w);
        logic signed [31:0] m;
        logic signed [5:0]  s;
        m = 32'(signed'(w[MAN_HI:0]));
        s = 6'(signed'(w[EXP_HI:EXP_LO])) + 6'sd6;
        lin_q = s[5] ? (m >>> 6'(-s)) : (m <<< s);
    endfunction

    // ==========================================================
    // Synchronisers
    logic [2:0] pwm_sr;
    logic [1:0] vin_st;
    logic [15:0] vin_s1;
    logic [15:0] vin_s2;
    logic pwm_edge;

    // Pins pass two flops; the third pwm stage only serves edge detection.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pwm_sr <= 3'b000;
            vin_s1 <= 16'h0000;
            vin_s2 <= 16'h0000;
            vin_st <= 2'b00;
        end else begin
            pwm_sr <= {pwm_sr[1:0], pwm_clk_in};
            vin_s1 <= power_input_voltage_in;
            vin_s2 <= vin_s1;
            vin_st <= {vin_st[0], 1'b1};    // Tracks when the voltage pipe holds a real sample.
        end
    end
    assign pwm_edge = pwm_sr[1] & ~pwm_sr[2];

    // ==========================================================
    // Command registers and status
    logic [15:0] ov_lim, uv_lim, ton_lim;
    logic [7:0]  act;
    logic [7:0]  si;
    logic        cml;
    logic [15:0] next_ov_lim, next_uv_lim, next_ton_lim;
    logic [7:0]  next_act, next_si;
    logic        next_cml;
    logic [15:0] next_rd_data, next_sw;
    logic        next_rd_valid;
    logic signed [31:0] wq, ovq, uvq, tonq, vq;
    logic        ov_now, uv_now;

    assign wq   = lin_q(cmd_in.data);
    assign ovq  = lin_q(ov_lim);
    assign uvq  = lin_q(uv_lim);
    assign tonq = lin_q(ton_lim);
    assign vq   = 32'(vin_s2);
    // Compares wait for a filled synchroniser, so its zero reset value raises no false warning.
    assign ov_now = vin_st[1] && (vq > ovq);
    assign uv_now = vin_st[1] && (vq < uvq);

    // Writes are checked before storing; a rejected write leaves the old value.
    always_comb begin
        next_ov_lim  = ov_lim;
        next_uv_lim  = uv_lim;
        next_ton_lim = ton_lim;
        next_act     = act;
        next_cml     = clear_faults_in ? 1'b0 : cml;
        next_si      = clear_faults_in ? 8'h00 : si;
        next_rd_valid = cmd_in.rd;
        next_rd_data = 16'h0000;
        if (cmd_in.wr) begin
            unique case (cmd_in.code)
                CMD_OV_LIMIT: begin
                    if (wq >= OV_MIN_Q && wq <= OV_MAX_Q && wq[OV_STEP_SH-1:0] == '0) begin
                        next_ov_lim = cmd_in.data;
                    end else begin
                        next_cml = 1'b1;
                    end
                end
                CMD_OV_ACTION: begin
                    if (cmd_in.data[SEL_HI:SEL_LO] != ACT_BAD) begin
                        next_act = cmd_in.data[7:0];
                    end else begin
                        next_cml = 1'b1;
                    end
                end
                CMD_UV_LIMIT: begin
                    if (wq >= UV_MIN_Q && wq <= UV_MAX_Q) begin
                        next_uv_lim = cmd_in.data;
                    end else begin
                        next_cml = 1'b1;
                    end
                end
                CMD_TURN_ON_DELAY_TIME: begin
                    if (wq >= 0 && wq <= TON_MAX_Q && wq[TON_STEP_SH-1:0] == '0) begin
                        next_ton_lim = cmd_in.data;
                    end else begin
                        next_cml = 1'b1;
                    end
                end
                default: next_cml = next_cml;
            endcase
        end
        // Restore rewrites the OV limit and turn-on delay on the stored grid, nearest step, clamped; the UV limit is kept.
        if (restore_in) begin
            next_ov_lim = {OV_EXP_RST, 11'((((ovq < OV_MIN_Q) ? OV_MIN_Q : (ovq > OV_MAX_Q) ? OV_MAX_Q : ovq)
                           + 8) >>> OV_STEP_SH)};
            next_ton_lim = {TON_EXP_RST, 11'((((tonq < 0) ? 0 : (tonq > TON_MAX_Q) ? TON_MAX_Q : tonq)
                            + 16) >>> TON_STEP_SH)};
        end
        unique case (cmd_in.code)
            CMD_OV_LIMIT:  next_rd_data = ov_lim;
            CMD_OV_ACTION: next_rd_data = {8'h00, act};
            CMD_UV_LIMIT:  next_rd_data = uv_lim;
            CMD_TURN_ON_DELAY_TIME: next_rd_data = ton_lim;
            default:       next_rd_data = 16'h0000;
        endcase
        // Hardware set wins over a clear in the same cycle.
        if (ov_now) next_si[SI_OV] = 1'b1;
        if (uv_now) next_si[SI_UVW] = 1'b1;
        next_sw = 16'h0000;
        next_sw[SW_INPUT] = |next_si;
        next_sw[SW_NOTA]  = |next_si;
        next_sw[SW_CML]   = next_cml;
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ov_lim <= OV_LIMIT_RST;
            uv_lim <= UV_LIMIT_RST;
            ton_lim <= TURN_ON_DELAY_TIME_RST;
            act <= ACTION_RST;
            si <= 8'h00;
            cml <= 1'b0;
            rd_data_out <= 16'h0000;
            rd_valid_out <= 1'b0;
            status_word_out <= 16'h0000;
            status_input_out <= 8'h00;
            alert_n_out <= 1'b1;
        end else begin
            ov_lim <= next_ov_lim;
            uv_lim <= next_uv_lim;
            ton_lim <= next_ton_lim;
            act <= next_act;
            si <= next_si;
            cml <= next_cml;
            rd_data_out <= next_rd_data;
            rd_valid_out <= next_rd_valid;
            status_word_out <= next_sw;
            status_input_out <= next_si;
            alert_n_out <= ~(|si | cml);    // Alert follows the bits by one cycle.
        end
    end

    // ==========================================================
    // Turn-on and fault response sequencer
    ivfs_state_t st, next_st;
    logic [31:0] cnt, next_cnt, ton_cyc;
    logic [2:0]  rep, next_rep, tries, next_tries, fac;
    logic [3:0]  dly_n;
    logic [2:0]  rty;
    logic        next_sw_en;

    assign rty = act[RTY_HI:RTY_LO];
    // Small codes share the shortest delay and single rise-time restart_wait_period.
    assign dly_n = (act[DLY_HI:0] < 3'd2) ? 4'(DLY_SHORT) :
                   (act[DLY_HI:0] < 3'd5) ? 4'(DLY_MID) : 4'(DLY_LONG);
    assign fac = (act[DLY_HI:0] == 3'd0) ? 3'd1 : act[DLY_HI:0];
    assign ton_cyc = 32'((64'(tonq[15:0]) * 64'(CYC_MS)) >> Q_FRAC);

    // Shutdown either latches or enters restart_wait_period; an attempt ends each restart_wait_period.
    always_comb begin
        next_st = st;
        next_cnt = cnt;
        next_rep = rep;
        next_tries = tries;
        if (!start_in) begin
            next_st = S_OFF;
            next_cnt = 32'h0000_0000;
        end else begin
            unique case (st)
                S_OFF: begin
                    next_st = S_TON;
                    next_cnt = 32'h0000_0000;
                end
                S_TON: begin
                    if (cnt >= ton_cyc && cnt >= 32'(MIN_TON)) begin
                        next_st = S_RUN;
                        next_tries = 3'd0;
                    end else begin
                        next_cnt = cnt + 32'h0000_0001;
                    end
                end
                S_RUN: begin
                    next_cnt = 32'h0000_0000;
                    next_rep = 3'd0;
                    if (ov_now && act[SEL_HI:SEL_LO] == ACT_DELAY) begin
                        next_st = S_DLY;
                    end else if (ov_now && act[SEL_HI:SEL_LO] == ACT_IMMED) begin
                        next_st = (rty == 3'd0) ? S_LAT : S_HIC;
                    end
                end
                S_DLY: begin
                    if (pwm_edge) begin
                        next_cnt = cnt + 32'h0000_0001;
                        if (cnt + 32'h0000_0001 >= 32'(dly_n)) begin
                            next_cnt = 32'h0000_0000;
                            next_st = !ov_now ? S_RUN : (rty == 3'd0) ? S_LAT : S_HIC;
                        end
                    end
                end
                S_HIC: begin
                    next_cnt = cnt + 32'h0000_0001;
                    if (cnt + 32'h0000_0001 >= 32'(rise_cycles_in)) begin
                        next_cnt = 32'h0000_0000;
                        next_rep = rep + 3'd1;
                        if (rep + 3'd1 >= fac) begin
                            next_rep = 3'd0;
                            next_tries = (tries == 3'd7) ? tries : tries + 3'd1;
                            if (!ov_now) begin
                                next_st = S_RUN;
                                next_tries = 3'd0;
                            end else if (rty != RTY_FOREVER && tries + 3'd1 >= rty) begin
                                next_st = S_LAT;
                            end
                        end
                    end
                end
                S_LAT: next_st = S_LAT;
                default: next_st = S_OFF;
            endcase
        end
        next_sw_en = (next_st == S_RUN) || (next_st == S_DLY);
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st <= S_OFF;
            cnt <= 32'h0000_0000;
            rep <= 3'd0;
            tries <= 3'd0;
            sw_en_out <= 1'b0;
        end else begin
            st <= next_st;
            cnt <= next_cnt;
            rep <= next_rep;
            tries <= next_tries;
            sw_en_out <= next_sw_en;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_imm_fault;
        st == S_RUN && start_in && ov_now && act[SEL_HI:SEL_LO] == ACT_IMMED;
    endsequence

    AST_OV_STATUS: assert property (ov_now |=> status_input_out[SI_OV] && status_word_out[SW_INPUT]
        ##1 !alert_n_out) else $error("overvoltage status or alert missing");
    AST_UV_STATUS: assert property (uv_now |=> status_input_out[SI_UVW] && status_word_out[SW_NOTA])
        else $error("undervoltage warning status missing");
    AST_IGNORE: assert property (st == S_RUN && start_in && act[SEL_HI:SEL_LO] == ACT_IGNORE
        |=> st == S_RUN && sw_en_out) else $error("ignore action stopped switching");
    AST_IMM_SHUT: assert property (s_imm_fault |=> !sw_en_out) else $error("immediate shutdown late");
    AST_LATCH_ZERO: assert property (s_imm_fault ##0 rty == 3'd0 |=> st == S_LAT)
        else $error("zero restart count did not latch");
    AST_BAD_ACTION: assert property (cmd_in.wr && cmd_in.code == CMD_OV_ACTION
        && cmd_in.data[SEL_HI:SEL_LO] == ACT_BAD |=> $stable(act) && status_word_out[SW_CML])
        else $error("invalid action byte accepted");
    AST_BAD_LIMIT: assert property (cmd_in.wr && cmd_in.code == CMD_OV_LIMIT
        && (wq < OV_MIN_Q || wq > OV_MAX_Q) |=> $stable(ov_lim) && status_word_out[SW_CML])
        else $error("out of range limit accepted");
    AST_MIN_TON: assert property (st == S_TON && start_in && cnt < 32'(MIN_TON)
        |=> !sw_en_out) else $error("turn-on delay shorter than minimum");
    AST_FOREVER: assert property (st == S_HIC && start_in && ov_now && rty == RTY_FOREVER
        |=> st == S_HIC) else $error("unlimited retry latched off");
    AST_DLY_HOLD: assert property (st == S_DLY && start_in && !pwm_edge |=> st == S_DLY && sw_en_out)
        else $error("delayed shutdown ended without a pwm edge");
endmodule

// *** src/ivfs_pkg.sv ***
// Constants, types and command map of the input voltage fault supervisor.
package ivfs_pkg;
    // ==========================================================
    // Command codes and field positions
    localparam logic [7:0] CMD_OV_LIMIT  = 8'h55;
    localparam logic [7:0] CMD_OV_ACTION = 8'h56;
    localparam logic [7:0] CMD_UV_LIMIT  = 8'h58;
    localparam logic [7:0] CMD_TURN_ON_DELAY_TIME = 8'h60;
    localparam int EXP_HI = 15;
    localparam int EXP_LO = 11;
    localparam int MAN_HI = 10;
    localparam int SEL_HI = 7;
    localparam int SEL_LO = 6;
    localparam int RTY_HI = 5;
    localparam int RTY_LO = 3;
    localparam int DLY_HI = 2;
    // ==========================================================
    // Reset values; mantissas are arbitrary stand-ins for stored defaults
    localparam logic [15:0] OV_LIMIT_RST  = 16'hF040;
    localparam logic [15:0] UV_LIMIT_RST  = 16'hF00C;
    localparam logic [15:0] TURN_ON_DELAY_TIME_RST = 16'hF800;
    localparam logic [7:0]  ACTION_RST    = 8'h80;
    localparam logic [4:0]  OV_EXP_RST    = 5'b11110;
    localparam logic [4:0]  TON_EXP_RST   = 5'b11111;
    // ==========================================================
    // Internal fixed point: 6 fraction bits (1/64 V or 1/64 ms)
    localparam int Q_FRAC     = 6;
    localparam int OV_MIN_Q   = 256;
    localparam int OV_MAX_Q   = 1280;
    localparam int OV_STEP_SH = 4;
    localparam int UV_MIN_Q   = 160;
    localparam int UV_MAX_Q   = 992;
    localparam int TON_MAX_Q  = 8160;
    localparam int TON_STEP_SH = 5;
    // ==========================================================
    // Timing
    localparam int CLK_MHZ    = 50;
    localparam int MIN_TON_US = 100;
    localparam int CYC_PER_MS = CLK_MHZ * 1000;
    localparam int MIN_TON_CYC = MIN_TON_US * CLK_MHZ;
    localparam int DLY_SHORT = 1;
    localparam int DLY_MID   = 3;
    localparam int DLY_LONG  = 7;
    // ==========================================================
    // Status bit positions and action codes
    localparam int SW_INPUT = 13;
    localparam int SW_CML   = 1;
    localparam int SW_NOTA  = 0;
    localparam int SI_OV    = 7;
    localparam int SI_UVW   = 5;
    localparam logic [1:0] ACT_IGNORE = 2'b00;
    localparam logic [1:0] ACT_DELAY  = 2'b01;
    localparam logic [1:0] ACT_IMMED  = 2'b10;
    localparam logic [1:0] ACT_BAD    = 2'b11;
    localparam logic [2:0] RTY_FOREVER = 3'd7;

    typedef enum logic [2:0] {
        S_OFF = 3'b000,
        S_TON = 3'b001,
        S_RUN = 3'b010,
        S_DLY = 3'b011,
        S_HIC = 3'b100,
        S_LAT = 3'b101
    } ivfs_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  code;
        logic [15:0] data;
    } ivfs_cmd_t;
endpackage

// *** verification/ivfs_host_model.sv ***
// Host controller model that issues command strobes and collects read answers.
module ivfs_host_model
    import ivfs_pkg::*;
(
    input  wire logic                mclk_in,
    input  wire logic [15:0]         rd_data_in,
    input  wire logic                rd_valid_in,
    output ivfs_pkg::ivfs_cmd_t      cmd_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Command strobes
    // Idle cycles after a strobe carry inverted code and data so a stale field is never mistaken for a live one.
    initial cmd_out = '0;

    // A write strobe stands for exactly one edge, then the fields are scrambled.
    task automatic write_cmd(input logic [7:0] code, input logic [15:0] data);
        @(posedge mclk_in);
        cmd_out <= '{wr: 1'b1, rd: 1'b0, code: code, data: data};
        @(posedge mclk_in);
        cmd_out <= '{wr: 1'b0, rd: 1'b0, code: ~code, data: ~data};
    endtask

    // The answer is registered at the edge that takes the strobe, so it is sampled just after it.
    task automatic read_cmd(input logic [7:0] code, output logic [15:0] data, output logic ok);
        @(posedge mclk_in);
        cmd_out <= '{wr: 1'b0, rd: 1'b1, code: code, data: 16'h0000};
        @(posedge mclk_in);
        cmd_out <= '{wr: 1'b0, rd: 1'b0, code: ~code, data: 16'hFFFF};
        #1;
        ok = rd_valid_in;
        data = rd_data_in;
    endtask
endmodule

// *** verification/ivfs_top_test.sv ***
// Self-checking testbench of the input voltage fault supervisor.
`define CHK(nm, exp, got) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
        end \
    end
module ivfs_top_test;
    import ivfs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // Short counts keep turn-on waits to tens of cycles.
    localparam int TB_CYC_MS = 64;
    localparam int TB_MIN_TON = 20;
    localparam logic [15:0] V_NOM = 16'h0300;
    localparam logic [15:0] V_HIGH = 16'h0440;
    localparam logic [15:0] V_LOW = 16'h00A0;
    logic mclk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic clear_faults_in = 1'b0;
    logic restore_in = 1'b0;
    logic start_in = 1'b0;
    logic [15:0] power_input_voltage_in = V_NOM;
    logic [15:0] rise_cycles_in = 16'h000A;
    logic pwm_clk_in = 1'b0;
    ivfs_cmd_t cmd;
    logic [15:0] rd_data_out;
    logic rd_valid_out;
    logic [15:0] status_word_out;
    logic [7:0] status_input_out;
    logic alert_n_out;
    logic sw_en_out;
    int errors = 0;
    int total_checks = 0;

    // ==========================================================
    // Clocks and instances
    // The switching clock is 160 ns and starts off-phase so its edges never line up with the system clock.
    initial forever #10 mclk_in = ~mclk_in;
    initial begin
        #37;
        forever #80 pwm_clk_in = ~pwm_clk_in;
    end

    ivfs_top #(.CYC_MS(TB_CYC_MS), .MIN_TON(TB_MIN_TON)) DUT (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in), .cmd_in(cmd), .clear_faults_in(clear_faults_in),
        .restore_in(restore_in), .start_in(start_in), .power_input_voltage_in(power_input_voltage_in),
        .rise_cycles_in(rise_cycles_in), .pwm_clk_in(pwm_clk_in), .rd_data_out(rd_data_out),
        .rd_valid_out(rd_valid_out), .status_word_out(status_word_out), .status_input_out(status_input_out),
        .alert_n_out(alert_n_out), .sw_en_out(sw_en_out));
    ivfs_host_model host (.mclk_in(mclk_in), .rd_data_in(rd_data_out), .rd_valid_in(rd_valid_out), .cmd_out(cmd));

    // ==========================================================
    // Shared tasks
    task automatic end_sim();
        if (errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        host.read_cmd(code, d, ok);
        `CHK("rd_valid", 1'b1, ok)
        `CHK("rd_data", exp, d)
    endtask

    task automatic clear();
        @(posedge mclk_in) clear_faults_in <= 1'b1;
        @(posedge mclk_in) clear_faults_in <= 1'b0;
    endtask

    // Bounded wait for the switch enable to reach a level; n returns the cycles spent.
    task automatic wait_sw(input logic lvl, input int lim, output int n);
        n = 0;
        while (sw_en_out !== lvl && n < lim) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
    endtask

    // Restart from OFF with a given fault action; a low start also clears any latch-off.
    task automatic run_up(input logic [7:0] act, output int n);
        host.write_cmd(CMD_OV_ACTION, {8'h00, act});
        @(posedge mclk_in) start_in <= 1'b0;
        power_input_voltage_in <= V_NOM;
        clear();
        start_in <= 1'b1;
        wait_sw(1'b1, 400, n);
    endtask

    task automatic set_v(input logic [15:0] v, input int cyc);
        @(posedge mclk_in) power_input_voltage_in <= v;
        repeat (cyc) @(posedge mclk_in);
        #1;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_registers();
        logic [7:0] c [6] = '{CMD_OV_LIMIT, CMD_OV_LIMIT, CMD_OV_ACTION, CMD_UV_LIMIT, CMD_TURN_ON_DELAY_TIME, 8'h57};
        logic [15:0] w [6] = '{16'hF050, 16'hF001, 16'h00C0, 16'hF040, 16'hF900, 16'h1234};
        logic [15:0] e [6] = '{16'hF050, 16'hF050, {8'h00, ACTION_RST}, UV_LIMIT_RST, TURN_ON_DELAY_TIME_RST, 16'h0000};
        logic b [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        logic [15:0] d;
        logic ok;
        rd_chk(CMD_OV_LIMIT, OV_LIMIT_RST);
        host.read_cmd(CMD_OV_LIMIT, d, ok);
        `CHK("ov_exp_default", OV_EXP_RST, d[EXP_HI:EXP_LO])
        rd_chk(CMD_UV_LIMIT, UV_LIMIT_RST);
        for (int i = 0; i < 6; i++) begin
            clear();
            host.write_cmd(c[i], w[i]);
            repeat (3) @(posedge mclk_in);
            #1;
            `CHK("cml_flag", b[i], status_word_out[SW_CML])
            `CHK("alert_n", ~b[i], alert_n_out)
            rd_chk(c[i], e[i]);
        end
        @(posedge mclk_in) restore_in <= 1'b1;
        @(posedge mclk_in) restore_in <= 1'b0;
        rd_chk(CMD_OV_LIMIT, 16'hF050);
        host.write_cmd(CMD_OV_LIMIT, OV_LIMIT_RST);
    endtask

    task automatic t_turn_on();
        int n;
        run_up(ACTION_RST, n);
        `CHK("min_turn_on", 1'b1, n >= TB_MIN_TON && n <= TB_MIN_TON + 6)
        host.write_cmd(CMD_TURN_ON_DELAY_TIME, 16'hF802);
        run_up(ACTION_RST, n);
        `CHK("turn_on_1ms", 1'b1, n >= TB_CYC_MS && n <= TB_CYC_MS + 6)
        host.write_cmd(CMD_TURN_ON_DELAY_TIME, TURN_ON_DELAY_TIME_RST);
    endtask

    task automatic t_immediate_latch();
        int n;
        run_up(8'h80, n);
        set_v(V_HIGH, 8);
        `CHK("ov_shutdown", 1'b0, sw_en_out)
        `CHK("ov_status", 3'b111, {status_input_out[SI_OV], status_word_out[SW_INPUT], status_word_out[SW_NOTA]})
        `CHK("ov_alert_n", 1'b0, alert_n_out)
        set_v(V_NOM, 100);
        `CHK("latched_off", 1'b0, sw_en_out)
    endtask

    // A short fault measures one restart wait; a held fault checks the retry budget.
    task automatic t_retry(input logic [7:0] act, input int hic, input int hold, input logic on);
        int n;
        run_up(act, n);
        set_v(V_HIGH, 0);
        wait_sw(1'b0, 20, n);
        set_v(V_NOM, 0);
        wait_sw(1'b1, 400, n);
        `CHK("restart_wait", 1'b1, n >= hic - 2 && n <= hic + 6)
        set_v(V_HIGH, hold);
        set_v(V_NOM, 0);
        wait_sw(1'b1, 2 * hic + 10, n);
        `CHK("after_retries", on, sw_en_out)
    endtask

    task automatic t_delayed_and_ignore();
        int n;
        run_up(8'h43, n);
        set_v(V_HIGH, 10);
        `CHK("delay_still_on", 1'b1, sw_en_out)
        wait_sw(1'b0, 60, n);
        `CHK("delay_then_off", 1'b0, sw_en_out)
        // Three switching edges, eight cycles apart, land 10 to 17 cycles after this point.
        `CHK("delay_clocks", 1'b1, n >= 8 && n <= 19)
        run_up(8'h00, n);
        set_v(V_HIGH, 40);
        `CHK("ignore_on", 1'b1, sw_en_out)
        `CHK("ignore_flag", 1'b1, status_input_out[SI_OV])
        set_v(V_LOW, 8);
        `CHK("uv_flags", 3'b111, {status_input_out[SI_UVW], status_word_out[SW_INPUT], status_word_out[SW_NOTA]})
        `CHK("uv_alert_n", 1'b0, alert_n_out)
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (10) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        #1;
        `CHK("reset_status", 16'h0000, status_word_out)
        `CHK("reset_alert_n", 1'b1, alert_n_out)
        t_registers();
        t_turn_on();
        t_immediate_latch();
        // The fault outlasts the second attempt but not a third, so a miscounted budget restarts.
        t_retry(8'h90, 10, 26, 1'b0);
        t_retry(8'hBD, 50, 300, 1'b1);
        t_delayed_and_ignore();
        end_sim();
    end

    // The full run needs well under 400 us; reaching this means something hung.
    initial begin
        #1000us;
        errors++;
        end_sim();
    end
endmodule
